/* rtl/led_ctl_pkg.sv */
// Shared constants, types and register map of the LED supervision block
package led_ctl_pkg;

  // ==========================================================================
  // Clocking and timing
  // ==========================================================================
  localparam int CLK_HZ           = 20_000_000;
  localparam int INT_OSC_HZ       = 350_000;
  localparam int INT_OSC_MIN_HZ   = 100_000;
  localparam int INT_OSC_MAX_HZ   = 700_000;
  // Rounds down
  localparam int INT_OSC_DIV      = CLK_HZ / INT_OSC_HZ;
  localparam int SLEEP_OSC_CYCLES = 32768;
  localparam int BLANK_OSC_CYCLES = 1024;
  localparam int OSC_DIV_W        = 8;
  localparam int OSC_CNT_W        = 16;

  // ==========================================================================
  // Wishbone register map
  // ==========================================================================
  localparam int          ADR_W          = 4;
  localparam logic [3:0]  ADDR_PHASE     = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam int          PHASE_W        = 8;
  localparam logic [7:0]  PHASE_RST      = 8'h1C;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

  // Status register field positions
  localparam int ST_MODE_LSB  = 0;
  localparam int ST_UV_BIT    = 3;
  localparam int ST_SHORT_BIT = 4;
  localparam int ST_OPEN_BIT  = 5;
  localparam int ST_HOT_BIT   = 6;
  localparam int ST_FF1_BIT   = 7;
  localparam int ST_FF2_BIT   = 8;
  localparam int ST_GATE_BIT  = 9;
  localparam int ST_INT_BIT   = 10;
  localparam int ST_OVR1_BIT  = 11;
  localparam int ST_OVR2_BIT  = 12;
  localparam int ST_USED_W    = 13;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'b001,
    MODE_BLANK = 3'b010,
    MODE_RUN   = 3'b100
  } mode_e;

  // Comparator outputs and logic inputs from the analog side
  typedef struct packed {
    logic enable;
    logic timing;
    logic reg_low;
    logic reg_on;
    logic out_short;
    logic string_short;
    logic open_led;
    logic under_current;
    logic temp_hot;
    logic temp_cool;
    logic led_short;
    logic peak_trip;
  } sense_s;

  localparam int SENSE_W = $bits(sense_s);

endpackage

/* rtl/sense_sync.sv */
// Two-stage synchroniser bank for the analog comparator and pin inputs
`timescale 1ns/1ns
module sense_sync (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire led_ctl_pkg::sense_s raw_i,
  output led_ctl_pkg::sense_s      synced_o
);
  import led_ctl_pkg::*;

  logic [SENSE_W-1:0] stage1;
  logic [SENSE_W-1:0] stage2;

  // ==========================================================================
  // One synchroniser per bit; stage1 feeds stage2 only
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < SENSE_W; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
        end else begin
          stage1[g] <= raw_i[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate

  assign synced_o = sense_s'(stage2);

endmodule // sense_sync

/* rtl/led_fault_ctl.sv */
// Supervision logic of a constant-current LED converter controller
//
// How it works
// RQ1 - Enable low past sleep delay enters sleep
// RQ2 - Sleep delay is 32768 oscillator periods
// RQ3 - Gate drive off whenever enable is low
// RQ4 - Controller keeps PWM period below sleep delay
// RQ5 - LED current follows enable, full or zero
// RQ6 - Tied timing pin selects internal 350 kHz
// RQ7 - External clock accepted; phased clock lags switching
// RQ8 - Flags pull low, release while fault present
// RQ9 - Undervoltage: gate low, both flags released
// RQ10 - Outputs stay off until above turn-on threshold
// RQ11 - Output short latched: critical released, gate off
// RQ12 - Open LED latched: general released, gate off
// RQ13 - Undercurrent releases general flag, keeps driving
// RQ14 - Overtemperature flag clears below recovery threshold
// RQ15 - Fault detection waits out start-up blanking
// RQ16 - Open LED detection ignores blanking
// RQ17 - Critical flag held low overrides short disable
// RQ18 - General flag held low overrides open disable
// RQ19 - Single shorted LED releases general flag, unlatched
// RQ20 - Comparators and enable pass two-stage synchroniser
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
module led_fault_ctl #(
  parameter int SLEEP_CYCLES = led_ctl_pkg::SLEEP_OSC_CYCLES,
  parameter int BLANK_CYCLES = led_ctl_pkg::BLANK_OSC_CYCLES
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone classic slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [led_ctl_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Analog comparators and logic pins
  input  wire led_ctl_pkg::sense_s     sense_i,
  input  wire logic                    timing_pin_tied_i,
  // Open-drain fault flags
  input  wire logic                    critical_fault_flag_i,
  output logic                         critical_fault_flag_o,
  output logic                         critical_fault_flag_oe_o,
  input  wire logic                    general_fault_flag_i,
  output logic                         general_fault_flag_o,
  output logic                         general_fault_flag_oe_o,
  // Power stage
  output logic                         switch_gate_drive_o,
  output logic                         led_current_on_o,
  output logic                         phased_clock_output_o
);
  import led_ctl_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  sense_s               sense;
  mode_e                mode;
  mode_e                next_mode;
  logic                 osc_internal;
  logic                 strap_taken;
  logic [OSC_DIV_W-1:0] div_cnt;
  logic                 timing_prev;
  logic                 osc_tick;
  logic [OSC_CNT_W-1:0] sleep_cnt;
  logic [OSC_CNT_W-1:0] blank_cnt;
  logic                 sleep_due;
  logic                 blank_done;
  logic                 uv;
  logic                 short_latch;
  logic                 open_latch;
  logic                 hot;
  logic                 detect_en;
  logic                 ovr_critical;
  logic                 ovr_general;
  logic                 hard_disable;
  logic                 gate_permit;
  logic                 rel_critical;
  logic                 rel_general;
  logic [PHASE_W-1:0]   phase_dly;
  logic [PHASE_W-1:0]   phase_cnt;
  logic                 flag_level;
  logic                 bus_req;
  logic                 bus_write;
  logic                 hit_phase;
  logic                 hit_status;
  logic [31:0]          status_word;
  logic [31:0]          next_rdata;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  sense_sync u_sense_sync (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .raw_i    (sense_i),  // [RQ20]
    .synced_o (sense)
  );

  // ==========================================================================
  // Oscillator source and tick
  // ==========================================================================
  // Strap caught one cycle after reset release, never inside reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_taken  <= 1'b0;
      osc_internal <= 1'b1;
    end else if (!strap_taken) begin
      strap_taken  <= 1'b1;
      osc_internal <= timing_pin_tied_i;  // [RQ6]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt     <= '0;
      timing_prev <= 1'b0;
    end else begin
      timing_prev <= sense.timing;
      if (div_cnt == OSC_DIV_W'(INT_OSC_DIV - 1)) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end

  // Internal divider or rising edge of the external clock
  assign osc_tick = osc_internal ? (div_cnt == OSC_DIV_W'(INT_OSC_DIV - 1))  // [RQ6]
                                 : (sense.timing && !timing_prev);           // [RQ7]

  // ==========================================================================
  // Sleep and blanking timers, counted in oscillator periods
  // ==========================================================================
  // Needs SLEEP_CYCLES ticks of unbroken low enable;
  // a PWM high phase restarts the count
  assign sleep_due  = !sense.enable && osc_tick &&
                      (sleep_cnt == OSC_CNT_W'(SLEEP_CYCLES - 1));  // [RQ2] [RQ4]
  assign blank_done = osc_tick && (blank_cnt == OSC_CNT_W'(BLANK_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_cnt <= '0;
    end else if (sense.enable || mode == MODE_SLEEP) begin
      sleep_cnt <= '0;
    end else if (osc_tick) begin
      sleep_cnt <= sleep_cnt + 1'b1;  // [RQ2]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blank_cnt <= '0;
    end else if (mode != MODE_BLANK || uv) begin
      blank_cnt <= '0;
    end else if (osc_tick) begin
      blank_cnt <= blank_cnt + 1'b1;  // [RQ15]
    end
  end

  // ==========================================================================
  // Operating mode
  // ==========================================================================
  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_SLEEP: begin
        if (sense.enable) begin
          next_mode = MODE_BLANK;
        end
      end
      MODE_BLANK: begin
        if (sleep_due) begin
          next_mode = MODE_SLEEP;  // [RQ1]
        end else if (blank_done && !uv) begin
          next_mode = MODE_RUN;  // [RQ15]
        end
      end
      MODE_RUN: begin
        if (sleep_due) begin
          next_mode = MODE_SLEEP;  // [RQ1]
        end else if (uv) begin
          next_mode = MODE_BLANK;  // [RQ10]
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= MODE_BLANK;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================================================
  // Fault state
  // ==========================================================================
  assign detect_en = (mode == MODE_RUN);  // [RQ15]

  // Undervoltage with hysteresis: set below low threshold, clear above on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uv <= 1'b1;
    end else if (sense.reg_low) begin
      uv <= 1'b1;  // [RQ9]
    end else if (sense.reg_on) begin
      uv <= 1'b0;  // [RQ10]
    end
  end

  // Overtemperature warning with hysteresis
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hot <= 1'b0;
    end else if (sense.temp_hot && detect_en) begin
      hot <= 1'b1;  // [RQ14]
    end else if (sense.temp_cool || mode == MODE_SLEEP) begin
      hot <= 1'b0;  // [RQ14]
    end
  end

  // Shorts clear only by sleep or reset; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      short_latch <= 1'b0;
    end else if (detect_en && (sense.out_short || sense.string_short)) begin
      short_latch <= 1'b1;  // [RQ11]
    end else if (mode == MODE_SLEEP) begin
      short_latch <= 1'b0;  // [RQ11]
    end
  end

  // Open LED ignores blanking; low enable clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_latch <= 1'b0;
    end else if (sense.open_led && mode != MODE_SLEEP && !uv) begin
      open_latch <= 1'b1;  // [RQ12] [RQ16]
    end else if (!sense.enable) begin
      open_latch <= 1'b0;  // [RQ12]
    end
  end

  // ==========================================================================
  // Flag overrides and gate permission
  // ==========================================================================
  // Released flag read low: held by the controller
  assign ovr_critical = short_latch && !critical_fault_flag_oe_o &&
                        !critical_fault_flag_i;  // [RQ17]
  assign ovr_general  = open_latch && !general_fault_flag_oe_o &&
                        !general_fault_flag_i;  // [RQ18]

  assign hard_disable = (short_latch && !ovr_critical) ||   // [RQ11] [RQ17]
                        (open_latch && !ovr_general);       // [RQ12] [RQ18]

  // Warnings never stop switching
  assign gate_permit  = (mode != MODE_SLEEP) && !uv && sense.enable &&
                        !hard_disable;  // [RQ3] [RQ9] [RQ10] [RQ13] [RQ19]

  // ==========================================================================
  // Fault flag encoding
  // ==========================================================================
  assign rel_critical = (mode == MODE_SLEEP) || uv || short_latch;  // [RQ8] [RQ9] [RQ11]
  assign rel_general  = (mode == MODE_SLEEP) || uv || open_latch || hot ||  // [RQ12] [RQ14]
                        (detect_en && sense.under_current) ||              // [RQ13]
                        (detect_en && sense.led_short);                    // [RQ19]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      critical_fault_flag_oe_o <= 1'b0;
      general_fault_flag_oe_o  <= 1'b0;
      flag_level               <= 1'b0;
    end else begin
      critical_fault_flag_oe_o <= !rel_critical;  // [RQ8]
      general_fault_flag_oe_o  <= !rel_general;   // [RQ8]
      flag_level               <= 1'b0;
    end
  end

  // Open drain: the pin is only ever driven low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      critical_fault_flag_o <= 1'b0;
      general_fault_flag_o  <= 1'b0;
    end else begin
      critical_fault_flag_o <= flag_level;
      general_fault_flag_o  <= flag_level;
    end
  end

  // ==========================================================================
  // Gate drive and LED current enable
  // ==========================================================================
  // Set on each oscillator tick, ended by the peak current comparator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      switch_gate_drive_o <= 1'b0;
    end else if (!gate_permit) begin
      switch_gate_drive_o <= 1'b0;  // [RQ3] [RQ9]
    end else if (osc_tick) begin
      switch_gate_drive_o <= 1'b1;
    end else if (sense.peak_trip) begin
      switch_gate_drive_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_current_on_o <= 1'b0;
    end else begin
      led_current_on_o <= gate_permit;  // [RQ5]
    end
  end

  // ==========================================================================
  // Phased clock output
  // ==========================================================================
  // Rises phase_dly+1 cycles after a tick, falls at the next;
  // too long a delay keeps it low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_cnt <= '0;
    end else if (osc_tick) begin
      phase_cnt <= '0;
    end else if (phase_cnt != '1) begin
      phase_cnt <= phase_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phased_clock_output_o <= 1'b0;
    end else if (osc_tick || mode == MODE_SLEEP) begin
      phased_clock_output_o <= 1'b0;
    end else if (phase_cnt == phase_dly) begin
      phased_clock_output_o <= 1'b1;  // [RQ7]
    end
  end

  // ==========================================================================
  // Wishbone slave
  // ==========================================================================
  assign bus_req    = wb_cyc_i && wb_stb_i;
  assign bus_write  = bus_req && wb_we_i && wb_ack_o;
  assign hit_phase  = (wb_adr_i == ADDR_PHASE);
  assign hit_status = (wb_adr_i == ADDR_STATUS);

  assign status_word = {{(32 - ST_USED_W){1'b0}},
                        ovr_general,
                        ovr_critical,
                        osc_internal,
                        switch_gate_drive_o,
                        !general_fault_flag_oe_o,
                        !critical_fault_flag_oe_o,
                        hot,
                        open_latch,
                        short_latch,
                        uv,
                        mode};

  assign next_rdata = hit_phase  ? {{(32 - PHASE_W){1'b0}}, phase_dly} :
                      hit_status ? status_word :
                      UNMAPPED_DATA;

  // Ack one cycle after the request; writes land on the acked edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_dly <= PHASE_RST;
    end else if (bus_write && hit_phase && wb_sel_i[0]) begin
      phase_dly <= wb_dat_i[PHASE_W-1:0];
    end
  end

endmodule // led_fault_ctl

/* verification/led_fault_ctl_monitor.sv */
// Port-level checker of the LED supervision block
`timescale 1ns/1ns
module led_fault_ctl_monitor (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire led_ctl_pkg::sense_s sense_i,
  input wire logic                critical_fault_flag_i,
  input wire logic                critical_fault_flag_o,
  input wire logic                critical_fault_flag_oe_o,
  input wire logic                general_fault_flag_i,
  input wire logic                general_fault_flag_o,
  input wire logic                general_fault_flag_oe_o,
  input wire logic                switch_gate_drive_o,
  input wire logic                led_current_on_o,
  input wire logic                phased_clock_output_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Register bus
  // ==========================================================================
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack longer than one cycle");
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack late");
  // ==========================================================================
  // Fault flags and gate
  // ==========================================================================
  property p_od_data;
    !critical_fault_flag_o && !general_fault_flag_o;
  endproperty
  a_od_data: assert property (p_od_data)
    else $error("flag data not low");
  property p_gate_en;
    (!sense_i.enable)[*6] |-> !switch_gate_drive_o;
  endproperty
  a_gate_en: assert property (p_gate_en)
    else $error("gate on, enable low");
  property p_cur_en;
    (!sense_i.enable)[*6] |-> !led_current_on_o;
  endproperty
  a_cur_en: assert property (p_cur_en)
    else $error("current on, enable low");
  property p_uv;
    sense_i.reg_low[*6] |-> !switch_gate_drive_o && !critical_fault_flag_oe_o
      && !general_fault_flag_oe_o;
  endproperty
  a_uv: assert property (p_uv)
    else $error("undervoltage not handled");
  // Short latch ends only by sleep or reset
  property p_short_hold;
    !critical_fault_flag_oe_o && general_fault_flag_oe_o |=> !critical_fault_flag_oe_o;
  endproperty
  a_short_hold: assert property (p_short_hold)
    else $error("short latch lost");
  property p_short_gate;
    (!critical_fault_flag_oe_o && general_fault_flag_oe_o && critical_fault_flag_i)[*5]
      |-> !switch_gate_drive_o;
  endproperty
  a_short_gate: assert property (p_short_gate)
    else $error("gate on during short");
  property p_open_gate;
    (sense_i.open_led && general_fault_flag_i)[*6] |-> !switch_gate_drive_o;
  endproperty
  a_open_gate: assert property (p_open_gate)
    else $error("gate on during open LED");
  c_short_ovr: cover property (!critical_fault_flag_oe_o && !critical_fault_flag_i);
  c_open_ovr: cover property (sense_i.open_led && !general_fault_flag_i);
  c_phase: cover property ($rose(phased_clock_output_o));
endmodule // led_fault_ctl_monitor

/* verification/fault_host_model.sv */
// Behavioural external controller: enable source and flag pull-ups
`timescale 1ns/1ns
module fault_host_model #(
  parameter int PWM_PERIOD = 40
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  input  wire logic pwm_i,
  input  wire logic hold_crit_i,
  input  wire logic hold_gen_i,
  input  wire logic crit_dat_i,
  input  wire logic crit_oe_i,
  input  wire logic gen_dat_i,
  input  wire logic gen_oe_i,
  output logic      enable_o,
  output logic      crit_pin_o,
  output logic      gen_pin_o
);
  logic [7:0] pwm_cnt;
  always @(posedge clk_i) begin
    if (rst_i || !pwm_i || pwm_cnt == 8'(PWM_PERIOD - 1))
      pwm_cnt <= 8'h00;
    else
      pwm_cnt <= pwm_cnt + 8'h01;
  end
  // Period far below the sleep delay
  assign enable_o = pwm_i ? (pwm_cnt < 8'(PWM_PERIOD / 2)) : level_i;
  // Pull-ups; a clamp holds a released pin low
  assign crit_pin_o = !((crit_oe_i && !crit_dat_i) || hold_crit_i);
  assign gen_pin_o = !((gen_oe_i && !gen_dat_i) || hold_gen_i);
endmodule // fault_host_model

/* verification/led_fault_ctl_tb.sv */
// Self-checking bench of the LED supervision block
`timescale 1ns/1ns
module led_fault_ctl_tb;
  import led_ctl_pkg::*;
  localparam int SLP = 4;
  localparam int BLK = 4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat = 32'h0, dat_o;
  sense_s      an = '0;
  sense_s      sense_bus;
  logic        level = 1'b1, pwm = 1'b0, hold_c = 1'b0, hold_g = 1'b0, peak = 1'b0, strap = 1'b1;
  logic        en, c_pin, g_pin, c_dat, c_oe, g_dat, g_oe, gate, cur, ph;
  int          err_count = 0, comparisons = 0, cyc_n = 0;
  always #25 clk_i = ~clk_i;
  // Peak trips a cycle after gate on
  always @(posedge clk_i) peak <= gate;
  assign sense_bus = {en, cyc_n[5], an[9:1], peak};
  led_fault_ctl #(.SLEEP_CYCLES(SLP), .BLANK_CYCLES(BLK)) u_led_fault_ctl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .sense_i(sense_bus), .timing_pin_tied_i(strap), .critical_fault_flag_i(c_pin),
    .critical_fault_flag_o(c_dat), .critical_fault_flag_oe_o(c_oe),
    .general_fault_flag_i(g_pin), .general_fault_flag_o(g_dat),
    .general_fault_flag_oe_o(g_oe), .switch_gate_drive_o(gate),
    .led_current_on_o(cur), .phased_clock_output_o(ph));
  fault_host_model u_fault_host_model (
    .clk_i(clk_i), .rst_i(rst_i), .level_i(level), .pwm_i(pwm), .hold_crit_i(hold_c),
    .hold_gen_i(hold_g), .crit_dat_i(c_dat), .crit_oe_i(c_oe), .gen_dat_i(g_dat),
    .gen_oe_i(g_oe), .enable_o(en), .crit_pin_o(c_pin), .gen_pin_o(g_pin));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic complete_run;
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rdat <= dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a);
    rw(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic wait_mode(input logic [2:0] m);
    do
      rd(ADDR_STATUS);
    while (rdat[2:0] !== m);
    check(32'(rdat[2:0]), 32'(m));
  endtask
  task automatic oe(input logic [1:0] exp);
    tick(8);
    check(32'({c_oe, g_oe}), 32'(exp));
  endtask
  task automatic gate_sw(input logic exp);
    int r;
    r = 0;
    repeat (150) begin
      @(posedge clk_i);
      r += int'(gate === 1'b1);
    end
    check(32'(r > 0), 32'(exp));
  endtask
  task automatic phase_low(output int n);
    n = 0;
    while (ph !== 1'b1)
      @(posedge clk_i);
    while (ph === 1'b1)
      @(posedge clk_i);
    while (ph !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // ==========================================================================
  // Timeout and main sequence
  // ==========================================================================
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    int n;
    tick(4);
    rst_i <= 1'b0;
    @(posedge clk_i);
    oe(2'b00);
    check(32'(gate), 32'h0);
    rd(ADDR_PHASE);
    check(rdat, {24'h0, PHASE_RST});
    rd(4'h8);
    check(rdat, UNMAPPED_DATA);
    rw(1'b1, ADDR_PHASE, 32'h05, 4'h0);
    rw(1'b1, ADDR_PHASE, 32'h05, 4'h1);
    rw(1'b1, ADDR_STATUS, 32'hFFFF, 4'hF);
    rd(ADDR_PHASE);
    check(rdat, 32'h05);
    rd(ADDR_STATUS);
    check(32'({rdat[ST_INT_BIT], rdat[ST_UV_BIT]}), 32'h3);
    an.reg_on <= 1'b1;
    an.under_current <= 1'b1;
    oe(2'b11);
    wait_mode(MODE_RUN);
    oe(2'b10);
    gate_sw(1'b1);
    an.under_current <= 1'b0;
    oe(2'b11);
    an.temp_hot <= 1'b1;
    oe(2'b10);
    gate_sw(1'b1);
    an.temp_hot <= 1'b0;
    oe(2'b10);
    an.temp_cool <= 1'b1;
    oe(2'b11);
    an.temp_cool <= 1'b0;
    an.led_short <= 1'b1;
    oe(2'b10);
    gate_sw(1'b1);
    an.led_short <= 1'b0;
    oe(2'b11);
    level <= 1'b0;
    tick(10);
    check(32'({gate, cur}), 32'h0);
    level <= 1'b1;
    tick(10);
    check(32'(cur), 32'h1);
    pwm <= 1'b1;
    tick(400);
    pwm <= 1'b0;
    rd(ADDR_STATUS);
    check(32'(rdat[2:0]), 32'(MODE_RUN));
    phase_low(n);
    check(32'(n), 32'd6);
    an.out_short <= 1'b1;
    tick(10);
    an.out_short <= 1'b0;
    oe(2'b01);
    gate_sw(1'b0);
    hold_c <= 1'b1;
    gate_sw(1'b1);
    hold_c <= 1'b0;
    gate_sw(1'b0);
    level <= 1'b0;
    tick(30);
    level <= 1'b1;
    oe(2'b01);
    level <= 1'b0;
    tick((SLP - 1) * INT_OSC_DIV - 10);
    rd(ADDR_STATUS);
    check(32'(rdat[2:0]), 32'(MODE_RUN));
    wait_mode(MODE_SLEEP);
    oe(2'b00);
    level <= 1'b1;
    an.open_led <= 1'b1;
    oe(2'b10);
    check(32'(gate), 32'h0);
    an.open_led <= 1'b0;
    oe(2'b10);
    rd(ADDR_STATUS);
    check(32'(rdat[ST_SHORT_BIT]), 32'h0);
    level <= 1'b0;
    tick(6);
    level <= 1'b1;
    oe(2'b11);
    wait_mode(MODE_RUN);
    an.open_led <= 1'b1;
    tick(10);
    an.open_led <= 1'b0;
    oe(2'b10);
    gate_sw(1'b0);
    hold_g <= 1'b1;
    gate_sw(1'b1);
    hold_g <= 1'b0;
    level <= 1'b0;
    tick(6);
    level <= 1'b1;
    oe(2'b11);
    an.reg_on <= 1'b0;
    an.reg_low <= 1'b1;
    oe(2'b00);
    gate_sw(1'b0);
    an.reg_low <= 1'b0;
    oe(2'b00);
    an.reg_on <= 1'b1;
    oe(2'b11);
    wait_mode(MODE_RUN);
    strap <= 1'b0;
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(2);
    rd(ADDR_STATUS);
    check(32'(rdat[ST_INT_BIT]), 32'h0);
    phase_low(n);
    check(32'(n), 32'(PHASE_RST) + 32'h1);
    complete_run();
  end
endmodule // led_fault_ctl_tb

bind led_fault_ctl led_fault_ctl_monitor u_led_fault_ctl_monitor (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sense_i, .critical_fault_flag_i,
  .critical_fault_flag_o, .critical_fault_flag_oe_o, .general_fault_flag_i,
  .general_fault_flag_o, .general_fault_flag_oe_o, .switch_gate_drive_o,
  .led_current_on_o, .phased_clock_output_o);
